// file: hw/xbar_pkg.sv
package xbar_pkg;

  // register offsets
  localparam logic [7:0] ADDR_PORT0_DATA   = 8'h80;
  localparam logic [7:0] ADDR_PORT1_DATA   = 8'h90;
  localparam logic [7:0] ADDR_PORT0_CFG    = 8'hA4;
  localparam logic [7:0] ADDR_PORT1_CFG    = 8'hA5;
  localparam logic [7:0] ADDR_ROUTE_A      = 8'hE1;
  localparam logic [7:0] ADDR_ROUTE_B      = 8'hE2;
  localparam logic [7:0] ADDR_ROUTE_C      = 8'hE3;

  // reset values
  localparam logic [7:0] RST_PORT_DATA     = 8'hFF;
  localparam logic [7:0] RST_PORT_CFG      = 8'h00;
  localparam logic [7:0] RST_ROUTE         = 8'h00;

  // route_select_a fields
  localparam int unsigned A_SMBUS          = 0;
  localparam int unsigned A_SPI            = 1;
  localparam int unsigned A_SERIAL         = 2;
  localparam int unsigned A_CMP_LSB        = 3;
  localparam int unsigned A_CMP_MSB        = 5;
  localparam int unsigned A_ECI            = 6;
  localparam int unsigned A_COMP0          = 7;
  localparam logic [2:0]  CMP_COUNT_MAX    = 3'h5;

  // route_select_c fields
  localparam int unsigned C_CONV_START     = 0;
  localparam int unsigned C_MASTER_EN      = 6;
  localparam int unsigned C_PULLUP_DIS     = 7;
  localparam logic [7:0]  ROUTE_C_MASK     = 8'hC1;

  // routed signals in priority order
  localparam int unsigned NUM_SIG          = 24;
  localparam int unsigned NUM_PINS         = 16;
  localparam int unsigned SIG_SDA          = 0;
  localparam int unsigned SIG_SCL          = 1;
  localparam int unsigned SIG_SCK          = 2;
  localparam int unsigned SIG_MISO         = 3;
  localparam int unsigned SIG_MOSI         = 4;
  localparam int unsigned SIG_NSS          = 5;
  localparam int unsigned SIG_TX           = 6;
  localparam int unsigned SIG_RX           = 7;
  localparam int unsigned SIG_CMP0         = 8;
  localparam int unsigned SIG_ECI          = 13;
  localparam int unsigned SIG_COMP0        = 14;
  localparam int unsigned SIG_TIMER0       = 16;
  localparam int unsigned SIG_CONV_START   = 23;
  // signals whose pin level comes from the peripheral; the rest are inputs
  localparam logic [23:0] SIG_OUT_MASK     = 24'h40DF7F;
  // signals forced open-drain on port 0
  localparam logic [23:0] SIG_OD_MASK      = 24'h000083;

endpackage

// file: hw/port_reg.sv
`timescale 1ns/1ps
module port_reg #(
  parameter logic [7:0] DATA_ADDR = 8'h00,
  parameter logic [7:0] CFG_ADDR  = 8'h00
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // register access
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       bit_wr,
  input  wire logic [2:0] bit_sel,
  input  wire logic       bit_wdata,
  // held values
  output logic      [7:0] latch,
  output logic      [7:0] cfg
);

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] cfg;
  } port_state_t;

  port_state_t state;
  port_state_t next_state;

  always_comb begin
    next_state = state;
    if (sfr_wr && sfr_addr == DATA_ADDR) begin
      next_state.latch = sfr_wdata;
    end
    if (bit_wr && sfr_addr == DATA_ADDR) begin
      next_state.latch[bit_sel] = bit_wdata;
    end
    if (sfr_wr && sfr_addr == CFG_ADDR) begin
      next_state.cfg = sfr_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= '{latch: xbar_pkg::RST_PORT_DATA, cfg: xbar_pkg::RST_PORT_CFG};
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign latch = state.latch;
  assign cfg   = state.cfg;

endmodule // port_reg

// file: hw/pin_cell.sv
`timescale 1ns/1ps
module pin_cell (
  // control
  input  wire logic xbar_en,
  input  wire logic value,
  input  wire logic push_pull,
  input  wire logic force_od,
  input  wire logic pud,
  // driver
  output logic      out,
  output logic      oe_n,
  output logic      pullup_on
);

  logic od;
  logic drive;

  always_comb begin
    od     = force_od | ~push_pull;
    // a one on an open-drain pin releases it
    drive  = xbar_en & (~value | ~od);
    out    = value;
    oe_n   = ~drive;
    // pull-up off while pulling low, saves static current
    pullup_on = ~pud & od & ~(drive & ~value);
  end

endmodule // pin_cell

// file: hw/priority_crossbar_port_io.sv
// Operation
// R1: counter module field routes first N compare outputs, codes 0..5; 6,7 reserved.
// R2: serial routing bit 2 routes receive and transmit together on two pins.
// R3: SPI routing bit 1 routes all four SPI signals as a group.
// R4: SMBus bit 0 puts SDA on port0 bit0 and SCL on bit1.
// R5: select_a bit 7 routes comparator 0, bit 6 the counter clock input.
// R6: select_b has one routing bit per timer, interrupt, clock and comparator signal.
// R7: select_c bit 7 clear enables pull-ups except push-pull; set disables all.
// R8: select_c bit 6 is the master crossbar enable.
// R9: select_c bits 5..1 read zero and ignore writes.
// R10: select_c bit 0 routes the converter start input.
// R11: enabled signals take consecutive pins from port0 bit0 upward in priority order.
// R12: unclaimed pins fall back to their port latch bits.
// R13: port data writes are latched and set the pin output levels.
// R14: ordinary port reads return actual pin levels, even for routed pins.
// R15: read-modify-write accesses read the latch instead of the pins.
// R16: port data registers accept byte and single-bit access.
// R17: latch 0 drives low; 1 drives high push-pull, else released.
// R18: output config bit 0 selects open-drain, 1 selects push-pull.
// R19: SDA, SCL, receive on port 0 are always open-drain.
// R20: registers of unpinned ports stay readable and writable.
// R21: software sets unpinned ports push-pull so they never float.
// R22: with the crossbar disabled every pin is an input.
// R23: weak pull-up on an open-drain pin is off while driving low.
// R24: a deselected peripheral's slot goes to the next selected signal.
// R25: fixed priority order SDA, SCL, SPI, serial, compares, ... converter start.
// R26: after reset routing and config registers zero, port latches all ones.
`timescale 1ns/1ps
module priority_crossbar_port_io (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // special function register access
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic        sfr_rmw,
  input  wire logic        bit_wr,
  input  wire logic [2:0]  bit_sel,
  input  wire logic        bit_wdata,
  output logic      [7:0]  sfr_rdata,
  // peripheral side, indexed in priority order
  input  wire logic [23:0] periph_out,
  output logic      [23:0] periph_in,
  // pins, port 1 in the upper byte
  input  wire logic [15:0] pin_in,
  output logic      [15:0] pin_out,
  output logic      [15:0] pin_oe_n,
  output logic      [15:0] pullup_en
);

  typedef struct packed {
    logic [7:0]  route_a;
    logic [7:0]  route_b;
    logic [7:0]  route_c;
    logic [7:0]  rdata;
    logic [23:0] periph_in;
    logic [15:0] pin_out;
    logic [15:0] pin_oe_n;
    logic [15:0] pullup_en;
  } xbar_state_t;

  xbar_state_t state;
  xbar_state_t next_state;

  logic [7:0]  latch0;
  logic [7:0]  latch1;
  logic [7:0]  cfg0;
  logic [7:0]  cfg1;
  logic [15:0] latch_all;
  logic [15:0] cfg_all;
  logic [23:0] sig_en;
  logic        xbar_en;
  logic        pud;
  logic [15:0] pin_value;
  logic [15:0] pin_force_od;
  logic [15:0] pin_routed;
  logic [4:0]  pin_sig [16];
  logic [15:0] cell_out;
  logic [15:0] cell_oe_n;
  logic [15:0] cell_pullup;

  // port registers hold regardless of pin count
  port_reg #(
    .DATA_ADDR(xbar_pkg::ADDR_PORT0_DATA),
    .CFG_ADDR (xbar_pkg::ADDR_PORT0_CFG)
  ) u_port0 (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .sfr_addr (sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_wr   (sfr_wr),
    .bit_wr   (bit_wr),
    .bit_sel  (bit_sel),
    .bit_wdata(bit_wdata),
    .latch    (latch0),
    .cfg      (cfg0)
  ); // [R13] [R16] [R20] [R26]

  port_reg #(
    .DATA_ADDR(xbar_pkg::ADDR_PORT1_DATA),
    .CFG_ADDR (xbar_pkg::ADDR_PORT1_CFG)
  ) u_port1 (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .sfr_addr (sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_wr   (sfr_wr),
    .bit_wr   (bit_wr),
    .bit_sel  (bit_sel),
    .bit_wdata(bit_wdata),
    .latch    (latch1),
    .cfg      (cfg1)
  ); // [R13] [R16] [R20] [R26]

  assign latch_all = {latch1, latch0};
  assign cfg_all   = {cfg1, cfg0};
  assign xbar_en   = state.route_c[xbar_pkg::C_MASTER_EN]; // [R8]
  assign pud       = state.route_c[xbar_pkg::C_PULLUP_DIS]; // [R7]

  // signal enables in priority order
  always_comb begin
    sig_en = '0;
    sig_en[1:0] = {2{state.route_a[xbar_pkg::A_SMBUS]}}; // [R4]
    sig_en[5:2] = {4{state.route_a[xbar_pkg::A_SPI]}}; // [R3]
    sig_en[7:6] = {2{state.route_a[xbar_pkg::A_SERIAL]}}; // [R2]
    for (int k = 0; k < 5; k++) begin
      // reserved codes exceed the maximum and route nothing
      sig_en[xbar_pkg::SIG_CMP0 + k] =
        (state.route_a[xbar_pkg::A_CMP_MSB:xbar_pkg::A_CMP_LSB] <= xbar_pkg::CMP_COUNT_MAX) &&
        (3'(k) < state.route_a[xbar_pkg::A_CMP_MSB:xbar_pkg::A_CMP_LSB]); // [R1]
    end
    sig_en[xbar_pkg::SIG_ECI]   = state.route_a[xbar_pkg::A_ECI]; // [R5]
    sig_en[xbar_pkg::SIG_COMP0] = state.route_a[xbar_pkg::A_COMP0]; // [R5]
    sig_en[xbar_pkg::SIG_COMP0 + 1] = state.route_b[0]; // [R6]
    // timer 0 .. system clock follow select_b bits 1..7 in order
    sig_en[xbar_pkg::SIG_TIMER0 +: 7] = state.route_b[7:1]; // [R6] [R25]
    sig_en[xbar_pkg::SIG_CONV_START] = state.route_c[xbar_pkg::C_CONV_START]; // [R10]
    if (!xbar_en) begin
      sig_en = '0; // [R22]
    end
  end

  // slot of each enabled signal is the count of enabled signals above it
  always_comb begin
    logic [4:0] slot;
    slot = '0;
    pin_routed = '0;
    for (int j = 0; j < 16; j++) begin
      pin_sig[j] = '0;
    end
    for (int i = 0; i < 24; i++) begin
      if (sig_en[i]) begin
        // slots past port 1 belong to port 2, which has no pins here
        if (slot < 5'd16) begin
          pin_routed[slot[3:0]] = 1'b1; // [R11] [R24]
          pin_sig[slot[3:0]]    = 5'(i);
        end
        slot = slot + 5'd1;
      end
    end
  end

  always_comb begin
    for (int j = 0; j < 16; j++) begin
      pin_value[j]    = latch_all[j]; // [R12]
      pin_force_od[j] = 1'b0;
      if (pin_routed[j]) begin
        // input-only signals keep the latch level, normally written high
        if (xbar_pkg::SIG_OUT_MASK[pin_sig[j]]) begin
          pin_value[j] = periph_out[pin_sig[j]];
        end
        pin_force_od[j] = (j < 8) && xbar_pkg::SIG_OD_MASK[pin_sig[j]]; // [R19]
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_pin
      pin_cell u_cell (
        .xbar_en  (xbar_en),
        .value    (pin_value[g]),
        .push_pull(cfg_all[g]),
        .force_od (pin_force_od[g]),
        .pud      (pud),
        .out      (cell_out[g]),
        .oe_n     (cell_oe_n[g]),
        .pullup_on(cell_pullup[g])
      ); // [R17] [R18] [R7] [R23]
    end
  endgenerate

  always_comb begin
    next_state           = state;
    next_state.pin_out   = cell_out;
    next_state.pin_oe_n  = cell_oe_n;
    next_state.pullup_en = cell_pullup;
    // unrouted signals see an idle high level
    next_state.periph_in = '1;
    for (int j = 0; j < 16; j++) begin
      if (pin_routed[j]) begin
        next_state.periph_in[pin_sig[j]] = pin_in[j];
      end
    end
    if (sfr_wr) begin
      unique case (sfr_addr)
        xbar_pkg::ADDR_ROUTE_A: next_state.route_a = sfr_wdata;
        xbar_pkg::ADDR_ROUTE_B: next_state.route_b = sfr_wdata;
        xbar_pkg::ADDR_ROUTE_C: next_state.route_c = sfr_wdata & xbar_pkg::ROUTE_C_MASK; // [R9]
        default: ;
      endcase
    end
    if (sfr_rd) begin
      unique case (sfr_addr)
        xbar_pkg::ADDR_PORT0_DATA: next_state.rdata = sfr_rmw ? latch0 : pin_in[7:0]; // [R14] [R15]
        xbar_pkg::ADDR_PORT1_DATA: next_state.rdata = sfr_rmw ? latch1 : pin_in[15:8]; // [R14] [R15]
        xbar_pkg::ADDR_PORT0_CFG:  next_state.rdata = cfg0;
        xbar_pkg::ADDR_PORT1_CFG:  next_state.rdata = cfg1;
        xbar_pkg::ADDR_ROUTE_A:    next_state.rdata = state.route_a;
        xbar_pkg::ADDR_ROUTE_B:    next_state.rdata = state.route_b;
        xbar_pkg::ADDR_ROUTE_C:    next_state.rdata = state.route_c;
        default:                   next_state.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state           <= '0;
      state.route_a   <= xbar_pkg::RST_ROUTE; // [R26]
      state.route_b   <= xbar_pkg::RST_ROUTE;
      state.route_c   <= xbar_pkg::RST_ROUTE;
      state.periph_in <= '1;
      state.pin_oe_n  <= '1;
      state.pullup_en <= '1;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign sfr_rdata = state.rdata;
  assign periph_in = state.periph_in;
  assign pin_out   = state.pin_out;
  assign pin_oe_n  = state.pin_oe_n;
  assign pullup_en = state.pullup_en;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_xbar_off_release: assert property ( // [R22]
    ce && !xbar_en |=> pin_oe_n == 16'hFFFF)
    else $error("pins driven while crossbar disabled");

  a_smbus_first_pins: assert property ( // [R4]
    ce && xbar_en && state.route_a[0] && periph_out[0] == 1'b0 && periph_out[1] == 1'b0
    |=> pin_oe_n[1:0] == 2'b00 && pin_out[1:0] == 2'b00)
    else $error("smbus signals not on first two pins");

  a_smbus_open_drain: assert property ( // [R19]
    ce && xbar_en && state.route_a[0] && periph_out[0] |=> pin_oe_n[0])
    else $error("sda high drives the pin");

  a_spi_group: assert property ( // [R3]
    ce && xbar_en && !state.route_a[0] && state.route_a[1]
    |=> pin_out[3:0] == $past(periph_out[5:2]))
    else $error("spi group not on pins 0..3");

  a_pullup_disable: assert property ( // [R7]
    ce && pud |=> pullup_en == 16'h0000)
    else $error("pull-up on while disabled");

  a_reserved_zero: assert property ( // [R9]
    ce && sfr_rd && sfr_addr == xbar_pkg::ADDR_ROUTE_C |=> sfr_rdata[5:1] == 5'h00)
    else $error("reserved bits read nonzero");

  a_pin_read_back: assert property ( // [R14]
    ce && sfr_rd && !sfr_rmw && sfr_addr == xbar_pkg::ADDR_PORT1_DATA
    |=> sfr_rdata == $past(pin_in[15:8]))
    else $error("port read not pin level");

  a_rmw_reads_latch: assert property ( // [R15]
    ce && sfr_rd && sfr_rmw && sfr_addr == xbar_pkg::ADDR_PORT0_DATA |=> sfr_rdata == $past(latch0))
    else $error("rmw read not latch");

  a_write_latched: assert property ( // [R13]
    ce && sfr_wr && sfr_addr == xbar_pkg::ADDR_PORT1_DATA |=> latch1 == $past(sfr_wdata))
    else $error("port write not latched");

  a_gpio_low_drive: assert property ( // [R12]
    ce && xbar_en && sig_en == 24'h0 && latch0[2] == 1'b0
    |=> pin_oe_n[2] == 1'b0 && pin_out[2] == 1'b0 && pullup_en[2] == 1'b0)
    else $error("latch zero not driving low");

  // unrouted signals read idle high, so a peripheral never sees a stray edge
  a_unrouted_idle_high: assert property ( // [R22]
    ce && !xbar_en |=> periph_in == 24'hFFFFFF)
    else $error("unrouted signal input not high");

  a_route_c_write: assert property ( // [R9]
    ce && sfr_wr && sfr_addr == xbar_pkg::ADDR_ROUTE_C
    |=> state.route_c[7:6] == $past(sfr_wdata[7:6]) && state.route_c[0] == $past(sfr_wdata[0])
        && state.route_c[5:1] == 5'h00)
    else $error("route select c write wrong");

  a_comp0_first_pin: assert property ( // [R5]
    ce && xbar_en && state.route_a == 8'h80 && cfg0[0]
    |=> !pin_oe_n[0] && pin_out[0] == $past(periph_out[xbar_pkg::SIG_COMP0]))
    else $error("comparator 0 not on first pin");

  a_irq0_next_slot: assert property ( // [R24]
    ce && xbar_en && state.route_a == 8'h80 && state.route_b == 8'h04
    |=> periph_in[17] == $past(pin_in[1]))
    else $error("interrupt 0 not on second pin");

  a_tx_after_spi: assert property ( // [R2]
    ce && xbar_en && state.route_a[2:0] == 3'h6 && cfg0[4]
    |=> !pin_oe_n[4] && pin_out[4] == $past(periph_out[xbar_pkg::SIG_TX]))
    else $error("transmit not after spi group");

  a_conv_start_slot: assert property ( // [R10]
    ce && xbar_en && state.route_a == 8'h00 && state.route_b == 8'h00 && state.route_c[0]
    |=> periph_in[xbar_pkg::SIG_CONV_START] == $past(pin_in[0]))
    else $error("converter start not on first pin");

  a_push_pull_high: assert property ( // [R18]
    ce && xbar_en && sig_en == 24'h0 && cfg1[0] && latch1[0]
    |=> !pin_oe_n[8] && pin_out[8])
    else $error("push-pull one not driven high");

  // the pull-up would only burn current against a low drive
  a_od_low_no_pullup: assert property ( // [R23]
    ce && xbar_en && !pud && sig_en == 24'h0 && !cfg1[5] && !latch1[5]
    |=> !pin_oe_n[13] && !pullup_en[13])
    else $error("pull-up on while driving low");

  a_bit_write_wins: assert property ( // [R16]
    ce && bit_wr && sfr_addr == xbar_pkg::ADDR_PORT1_DATA
    |=> latch1[$past(bit_sel)] == $past(bit_wdata))
    else $error("single-bit write not latched");

endmodule // priority_crossbar_port_io

// file: tb/pin_board.sv
`timescale 1ns/1ps
module pin_board (
  // clock
  input  wire logic        ref_clk,
  // device side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  input  wire logic [15:0] pullup_en,
  // external drivers on the board
  input  wire logic [15:0] ext_drv,
  input  wire logic [15:0] ext_val,
  output logic      [15:0] pin_in
);
  // a line with no driver and no pull-up toggles, so a stale level never passes by luck
  logic [15:0] float_val = 16'h0000;
  always @(posedge ref_clk) float_val <= ~float_val;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_drv[i]) pin_in[i] = ext_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_val[i];
    end
  end
endmodule // pin_board

// file: tb/priority_crossbar_port_io_tb.sv
`timescale 1ns/1ps
module priority_crossbar_port_io_tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic        sfr_rmw = 1'b0;
  logic        bit_wr = 1'b0;
  logic [2:0]  bit_sel = 3'h0;
  logic        bit_wdata = 1'b0;
  logic [7:0]  sfr_rdata;
  logic [23:0] periph_out = 24'h000000;
  logic [23:0] periph_in;
  logic [15:0] pin_in, pin_out, pin_oe_n, pullup_en;
  logic [15:0] ext_drv = 16'h0000;
  logic [15:0] ext_val = 16'h0000;
  int          miscompares = 0;
  int          checked = 0;

  always #50 ref_clk = ~ref_clk;

  priority_crossbar_port_io i_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .bit_wr(bit_wr),
    .bit_sel(bit_sel), .bit_wdata(bit_wdata), .sfr_rdata(sfr_rdata), .periph_out(periph_out),
    .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en));

  pin_board i_board (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
    .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge ref_clk);
    sfr_wr    <= 1'b0;
  endtask

  task automatic set_inputs(input logic [23:0] p, input logic [15:0] e);
    @(posedge ref_clk);
    periph_out <= p;
    ext_drv    <= e;
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic rmw, input logic [7:0] exp);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    sfr_rmw  <= rmw;
    @(posedge ref_clk);
    sfr_rd   <= 1'b0;
    sfr_rmw  <= 1'b0;
    @(negedge ref_clk);
    chk(what, sfr_rdata, exp);
  endtask

  // a register write reaches the pins one edge later
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    miscompares++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("oe_n reset", pin_oe_n, 16'hFFFF);
    chk("pullup reset", pullup_en, 16'hFFFF);
    rchk("cfg0 reset", xbar_pkg::ADDR_PORT0_CFG, 1'b0, 8'h00);
    rchk("cfg1 reset", xbar_pkg::ADDR_PORT1_CFG, 1'b0, 8'h00);
    rchk("route_a reset", xbar_pkg::ADDR_ROUTE_A, 1'b0, 8'h00);
    rchk("route_b reset", xbar_pkg::ADDR_ROUTE_B, 1'b0, 8'h00);
    rchk("route_c reset", xbar_pkg::ADDR_ROUTE_C, 1'b0, 8'h00);
    rchk("latch0 reset", xbar_pkg::ADDR_PORT0_DATA, 1'b1, 8'hFF);
    rchk("unmapped", 8'h55, 1'b0, 8'h00);
    wr(xbar_pkg::ADDR_ROUTE_C, 8'hFF);
    rchk("route_c unused", xbar_pkg::ADDR_ROUTE_C, 1'b0, 8'hC1);
    wr(xbar_pkg::ADDR_ROUTE_B, 8'hA5);
    rchk("route_b rw", xbar_pkg::ADDR_ROUTE_B, 1'b0, 8'hA5);
    // smbus plus two compare outputs, port 0 push-pull but sda and scl forced open-drain, scl held low on the board
    set_inputs(24'h000203, 16'h0002);
    wr(xbar_pkg::ADDR_PORT0_CFG, 8'hFF);
    wr(xbar_pkg::ADDR_ROUTE_B, 8'h00);
    wr(xbar_pkg::ADDR_ROUTE_A, 8'h11);
    wr(xbar_pkg::ADDR_ROUTE_C, 8'h40);
    settle();
    chk("smbus oe_n", pin_oe_n[7:0], 8'h03);
    chk("smbus drive", pin_out[7:0] & ~pin_oe_n[7:0], 8'hF8);
    chk("smbus in", periph_in[1:0], 2'b01);
    chk("port1 free", pin_oe_n[15:8], 8'hFF);
    // spi and serial groups
    set_inputs(24'h000054, 16'h0000);
    wr(xbar_pkg::ADDR_ROUTE_A, 8'h06);
    settle();
    chk("spi oe_n", pin_oe_n[7:0], 8'h20);
    chk("spi drive", pin_out[7:0] & ~pin_oe_n[7:0], 8'hD5);
    set_inputs(24'h000000, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      wr(xbar_pkg::ADDR_ROUTE_A, {2'b00, c[2:0], 3'b000});
      settle();
      chk("compare drive", pin_out[7:0], 8'((c < 6) ? (8'hFF << c) : 8'hFF));
      chk("compare oe_n", pin_oe_n[7:0], 8'h00);
    end
    // comparator 0, ext irq 0 and converter start fill the first three pins
    set_inputs(24'h004000, 16'h0006);
    wr(xbar_pkg::ADDR_PORT0_CFG, 8'h01);
    wr(xbar_pkg::ADDR_ROUTE_A, 8'h80);
    wr(xbar_pkg::ADDR_ROUTE_B, 8'h04);
    wr(xbar_pkg::ADDR_ROUTE_C, 8'h41);
    settle();
    chk("mix oe_n", pin_oe_n[2:0], 3'b110);
    chk("comp0 pin", pin_out[0], 1'b1);
    chk("irq conv in", {periph_in[23], periph_in[17]}, 2'b00);
    chk("rx unrouted", periph_in[7], 1'b1);
    // general purpose port 1 with one pin pulled low on the board
    set_inputs(24'h004000, 16'h4000);
    wr(xbar_pkg::ADDR_ROUTE_A, 8'h00);
    wr(xbar_pkg::ADDR_ROUTE_B, 8'h00);
    wr(xbar_pkg::ADDR_ROUTE_C, 8'h40);
    wr(xbar_pkg::ADDR_PORT1_CFG, 8'h0F);
    wr(xbar_pkg::ADDR_PORT1_DATA, 8'h5A);
    wr(xbar_pkg::ADDR_PORT0_DATA, 8'hFB);
    settle();
    chk("gpio oe_n", pin_oe_n[15:8], 8'h50);
    chk("gpio drive", pin_out[15:8] & ~pin_oe_n[15:8], 8'h0A);
    chk("gpio pullup", pullup_en[15:8], 8'h50);
    chk("gpio low", {pin_oe_n[2], pin_out[2], pullup_en[2]}, 3'h0);
    rchk("pin read", xbar_pkg::ADDR_PORT1_DATA, 1'b0, 8'h1A);
    rchk("latch read", xbar_pkg::ADDR_PORT1_DATA, 1'b1, 8'h5A);
    @(posedge ref_clk);
    sfr_addr  <= xbar_pkg::ADDR_PORT1_DATA;
    bit_sel   <= 3'h0;
    bit_wdata <= 1'b1;
    bit_wr    <= 1'b1;
    @(posedge ref_clk);
    bit_wr    <= 1'b0;
    rchk("bit write", xbar_pkg::ADDR_PORT1_DATA, 1'b1, 8'h5B);
    wr(xbar_pkg::ADDR_ROUTE_C, 8'hC0);
    settle();
    chk("pullup off", pullup_en[15:8], 8'h00);
    wr(xbar_pkg::ADDR_ROUTE_A, 8'h07);
    wr(xbar_pkg::ADDR_ROUTE_C, 8'h00);
    settle();
    chk("xbar off", pin_oe_n, 16'hFFFF);
    summarize();
  end
endmodule // priority_crossbar_port_io_tb
